// ==== sac_ctrl.sv ====
`timescale 1ns/1ps
// How it works
// - Idle falling edge on start input holds sampler and begins conversion.
// - Start input transitions are ignored while a conversion runs.
// - Conversion starts on the start edge whatever chip select shows.
// - Busy goes low within 120 ns, stays low until conversion ends.
// - Internal clock mode sends previous result during current conversion.
// - Result word is 12-bit two's complement, most significant bit first.
// - Internal mode data bit holds across both shift clock edges.
// - Busy stays low through the whole internal-clock transfer.
// - Internal shift clock period 1.1 us, high 250-500, low 600-875 ns.
// - First internal rising edge about 1.4 us after start falls.
// - Busy rises about 800 ns after the last internal falling edge.
// - Result copies into shift register just before busy rises.
// - External mode shifts only on host shift clock edges.
// - Codes 7ff, 000, fff, 800 map to the documented scale points.
// - Source select high makes shift clock an input, low an output.
// - Chip select high floats data, busy and driven shift clock.
// - Clock high and select low at update skips it, dropping new result.
// - After the 13th external rising edge, serial data goes low.
module sac_ctrl (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_conversion_start_n,
	input wire logic i_chip_select_n,
	input wire logic i_shift_clock_source_select,
	input wire logic i_serial_shift_clock,
	output logic o_serial_shift_clock,
	output logic o_serial_shift_clock_oe_n,
	output logic o_serial_data,
	output logic o_serial_data_oe_n,
	output logic o_busy_n,
	output logic o_busy_oe_n,
	output logic o_sample_hold,
	input wire logic i_result_valid,
	input wire logic [sac_pkg::RES_BITS-1:0] i_result_code,
	output logic o_result_ready
);
	import sac_pkg::*;

	typedef struct packed {
		sac_state_t state;
		logic [1:0] conversion_start_n_sy;
		logic [1:0] cs_sy;
		logic [1:0] sel_sy;
		logic [1:0] sck_sy;
		logic conversion_start_n_prev;
		logic sck_prev;
		logic tx;
		logic [8:0] tcount;
		logic [4:0] phase;
		logic [3:0] bitidx;
		logic [3:0] ecount;
		logic [RES_BITS-1:0] shreg;
		logic sdata;
		logic sck_out;
	} sac_ctrl_t;

	localparam sac_ctrl_t CTRL_RESET = '{
		state: ST_IDLE,
		conversion_start_n_sy: SYNC_HIGH,
		cs_sy: SYNC_HIGH,
		sel_sy: SYNC_LOW,
		sck_sy: SYNC_LOW,
		conversion_start_n_prev: 1'b1,
		sck_prev: 1'b0,
		tx: 1'b0,
		tcount: 9'h000,
		phase: 5'h00,
		bitidx: 4'h0,
		ecount: 4'h0,
		shreg: SHREG_RESET,
		sdata: 1'b0,
		sck_out: 1'b0
	};

	function automatic logic rise_of(input logic now, input logic prev);
		return now && !prev;
	endfunction

	sac_ctrl_t r;
	sac_ctrl_t next_r;
	logic conversion_start_n_fall;
	logic ext_mode;
	logic sck_rise;
	logic upd;
	logic upd_ok;
	logic buf_valid;
	logic [RES_BITS-1:0] buf_data;

	// Staging keeps a finished word while the shift register is still busy
	sac_buf2 u_buf (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_valid(i_result_valid),
		.i_data(i_result_code),
		.o_ready(o_result_ready),
		.o_valid(buf_valid),
		.o_data(buf_data),
		.i_ready(upd)
	);

	always_comb begin
		next_r = r;
		// Pins pass two flops before any logic looks at them
		next_r.conversion_start_n_sy = {r.conversion_start_n_sy[0], i_conversion_start_n};
		next_r.cs_sy = {r.cs_sy[0], i_chip_select_n};
		next_r.sel_sy = {r.sel_sy[0], i_shift_clock_source_select};
		next_r.sck_sy = {r.sck_sy[0], i_serial_shift_clock};
		next_r.conversion_start_n_prev = r.conversion_start_n_sy[1];
		next_r.sck_prev = r.sck_sy[1];

		// Chip select not part of the start condition
		conversion_start_n_fall = rise_of(!r.conversion_start_n_sy[1], !r.conversion_start_n_prev);
		ext_mode = r.sel_sy[1];
		// Chip select gates the host clock
		sck_rise = ext_mode && !r.cs_sy[1] && rise_of(r.sck_sy[1], r.sck_prev);
		upd = 1'b0;
		// Host clock must be low or select high as busy rises
		upd_ok = !ext_mode || r.cs_sy[1] || !r.sck_sy[1];

		if (sck_rise) begin
			if (r.ecount == 4'h0) begin
				next_r.ecount = 4'h1;
			end else if (r.ecount != EXT_STOP) begin
				// Zeros fill in behind, so the 13th edge leaves data low
				next_r.shreg = {r.shreg[RES_BITS-2:0], 1'b0};
				next_r.ecount = 4'(r.ecount + 4'h1);
			end
		end

		case (r.state)
			ST_IDLE: begin
				next_r.tx = 1'b0;
				if (conversion_start_n_fall) begin
					next_r.state = ST_CONVERSION_START_N;
					next_r.tcount = 9'h000;
					next_r.phase = 5'h00;
					next_r.bitidx = 4'h0;
				end
			end
			ST_CONVERSION_START_N: begin
				// Start edges fall through here untouched
				next_r.tcount = 9'(r.tcount + 9'h001);
				if ((r.tcount == FIRST_CYC - 9'h001) && !ext_mode) begin
					next_r.tx = 1'b1;
					next_r.phase = 5'h00;
					next_r.bitidx = 4'h0;
				end else if (r.tx) begin
					if (r.phase == PERIOD_CYC - 5'h01) begin
						next_r.phase = 5'h00;
						if (r.bitidx == LAST_BIT) begin
							next_r.tx = 1'b0;
						end else begin
							next_r.bitidx = 4'(r.bitidx + 4'h1);
						end
					end else begin
						next_r.phase = 5'(r.phase + 5'h01);
					end
					// Bit changes well after the falling edge, not on it
					if (r.phase == HIGH_CYC + HOLD_CYC - 5'h01) begin
						next_r.shreg = {r.shreg[RES_BITS-2:0], 1'b0};
					end
				end
				if (r.tcount == END_CYC - 9'h001) begin
					// Last cycle of busy: word is popped even when skipped
					upd = buf_valid;
					if (upd_ok && buf_valid) begin
						// Two's complement code passes through unchanged
						next_r.shreg = buf_data;
						next_r.ecount = 4'h0;
					end
					next_r.state = ST_IDLE;
					next_r.tx = 1'b0;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
				next_r.tx = 1'b0;
			end
		endcase

		if (ext_mode) begin
			next_r.sdata = (next_r.ecount != 4'h0) && next_r.shreg[RES_BITS-1];
		end else begin
			// Data low outside a transfer; MSB waits ready ahead of the first edge
			next_r.sdata = (next_r.state == ST_CONVERSION_START_N) && (next_r.tx || (next_r.tcount < FIRST_CYC))
				&& next_r.shreg[RES_BITS-1];
		end
		next_r.sck_out = !ext_mode && next_r.tx && (next_r.phase < HIGH_CYC);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= CTRL_RESET;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	// Combinational term keeps the start-to-busy delay within two sync flops
	assign o_busy_n = !((r.state == ST_CONVERSION_START_N) || conversion_start_n_fall);
	assign o_busy_oe_n = r.cs_sy[1];
	assign o_serial_data = r.sdata;
	assign o_serial_data_oe_n = r.cs_sy[1];
	assign o_serial_shift_clock = r.sck_out;
	assign o_serial_shift_clock_oe_n = r.cs_sy[1] || r.sel_sy[1];
	assign o_sample_hold = (r.state == ST_CONVERSION_START_N);

	// Checks assume the clock enable stays high
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence sck_high_run;
		o_serial_shift_clock [*7] ##1 !o_serial_shift_clock;
	endsequence

	sequence data_held;
		$stable(o_serial_data) [*8];
	endsequence

	sequence sck_low_run;
		##14 !o_serial_shift_clock ##1 o_serial_shift_clock;
	endsequence

	start_busy_a: assert property ((r.state == ST_IDLE) && conversion_start_n_fall
		|-> !o_busy_n ##1 (r.state == ST_CONVERSION_START_N) && (r.tcount == 9'h000))
		else $error("start edge did not begin a conversion");

	ignore_start_a: assert property ((r.state == ST_CONVERSION_START_N) && conversion_start_n_fall
		&& (r.tcount != END_CYC - 9'h001) |=> (r.tcount == $past(r.tcount) + 9'h001))
		else $error("start edge disturbed a running conversion");

	busy_len_a: assert property ($rose(o_busy_n) |->
		($past(r.tcount) == END_CYC - 9'h001) && (END_CYC < BUSY_MAX_CYC))
		else $error("busy low time wrong");

	first_edge_a: assert property ($rose(o_serial_shift_clock) && (r.bitidx == 4'h0)
		|-> (r.tcount == FIRST_CYC))
		else $error("first internal shift edge at wrong time");

	sck_high_a: assert property ($rose(o_serial_shift_clock) |-> sck_high_run)
		else $error("internal shift clock high phase wrong");

	data_hold_a: assert property ($rose(o_serial_shift_clock) |-> data_held)
		else $error("serial data moved around a shift edge");

	busy_frame_a: assert property (o_serial_shift_clock |-> !o_busy_n)
		else $error("shift clock outside busy frame");

	tail_busy_a: assert property ($fell(o_serial_shift_clock) && (r.bitidx == LAST_BIT)
		|-> ##15 !o_busy_n ##1 o_busy_n)
		else $error("busy tail after last shift edge wrong");

	ext_quiet_a: assert property ((r.ecount == EXT_STOP) && ext_mode |-> !o_serial_data)
		else $error("serial data not low after 13th edge");

	outputs_off_a: assert property (r.cs_sy[1] |-> o_serial_data_oe_n && o_busy_oe_n
		&& o_serial_shift_clock_oe_n)
		else $error("outputs driven with chip select high");

	skip_upd_a: assert property (upd && !upd_ok && !sck_rise
		|=> (r.shreg == $past(r.shreg)))
		else $error("shift register updated against clock rule");

	load_upd_a: assert property (upd && upd_ok |=> (r.shreg == $past(buf_data)))
		else $error("result not loaded at end of conversion");

	sck_low_a: assert property ($fell(o_serial_shift_clock) && (r.bitidx != LAST_BIT)
		|-> sck_low_run)
		else $error("internal shift clock low phase wrong");

	idle_quiet_a: assert property ((r.state == ST_IDLE) && !$past(r.sel_sy[1])
		|-> !o_serial_data && !o_serial_shift_clock)
		else $error("internal data or clock active outside a conversion");

	hold_start_a: assert property ($fell(o_busy_n) |=> o_sample_hold)
		else $error("sampler not in hold after start");

	busy_run_a: assert property ((r.state == ST_CONVERSION_START_N) && (r.tcount != END_CYC - 9'h001)
		|=> !o_busy_n && (r.state == ST_CONVERSION_START_N))
		else $error("busy released before the conversion ended");

	pop_end_a: assert property ((r.state == ST_CONVERSION_START_N) && (r.tcount == END_CYC - 9'h001)
		&& buf_valid |=> o_result_ready)
		else $error("finished word not taken from staging");

	ext_first_a: assert property (sck_rise && (r.ecount == 4'h0) && !upd
		|=> (o_serial_data == $past(r.shreg[RES_BITS-1])))
		else $error("first host edge did not present the top bit");

	ext_hold_a: assert property (ext_mode && !sck_rise && !upd && !r.tx
		|=> (r.shreg == $past(r.shreg)))
		else $error("shift register moved without a host edge");
endmodule // sac_ctrl

// ==== sac_pkg.sv ====
package sac_pkg;
	localparam int CLK_NS = 50;
	localparam int RES_BITS = 12;

	// Internal shift clock timing, typical figures
	localparam int FIRST_EDGE_NS = 1400;
	localparam int SCK_HIGH_NS = 350;
	localparam int SCK_PERIOD_NS = 1100;
	localparam int DATA_HOLD_NS = 400;
	localparam int BUSY_TAIL_NS = 800;
	localparam int BUSY_MAX_NS = 20000;

	localparam logic [8:0] FIRST_CYC = 9'(FIRST_EDGE_NS / CLK_NS);
	localparam logic [4:0] HIGH_CYC = 5'(SCK_HIGH_NS / CLK_NS);
	localparam logic [4:0] PERIOD_CYC = 5'(SCK_PERIOD_NS / CLK_NS);
	localparam logic [4:0] HOLD_CYC = 5'(DATA_HOLD_NS / CLK_NS);
	// Last falling edge plus tail; stays below the busy maximum
	localparam logic [8:0] END_CYC = 9'((FIRST_EDGE_NS + (RES_BITS - 1) * SCK_PERIOD_NS
		+ SCK_HIGH_NS + BUSY_TAIL_NS) / CLK_NS);
	localparam logic [8:0] BUSY_MAX_CYC = 9'(BUSY_MAX_NS / CLK_NS);

	localparam logic [3:0] LAST_BIT = 4'(RES_BITS - 1);
	localparam logic [3:0] EXT_STOP = 4'hd;

	// Synchroniser reset levels: inputs idle
	localparam logic [1:0] SYNC_HIGH = 2'h3;
	localparam logic [1:0] SYNC_LOW = 2'h0;
	localparam logic [11:0] SHREG_RESET = 12'h000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONVERSION_START_N = 2'b10
	} sac_state_t;
endpackage

// ==== sac_buf2.sv ====
`timescale 1ns/1ps
module sac_buf2 (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_valid,
	input wire logic [sac_pkg::RES_BITS-1:0] i_data,
	output logic o_ready,
	output logic o_valid,
	output logic [sac_pkg::RES_BITS-1:0] o_data,
	input wire logic i_ready
);
	import sac_pkg::*;

	typedef struct packed {
		logic [1:0][RES_BITS-1:0] mem;
		logic [1:0] count;
	} sac_buf_t;

	sac_buf_t r;
	sac_buf_t next_r;
	logic push;
	logic pop;
	logic slot;

	always_comb begin
		next_r = r;
		push = i_valid && (r.count != 2'h2);
		pop = i_ready && (r.count != 2'h0);
		slot = !((r.count == 2'h0) || ((r.count == 2'h1) && pop));
		if (pop) begin
			next_r.mem[0] = r.mem[1];
		end
		if (push) begin
			next_r.mem[slot] = i_data;
		end
		next_r.count = 2'(r.count + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '0;
		end else if (i_ce) begin
			r <= next_r;
		end
	end

	assign o_ready = (r.count != 2'h2);
	assign o_valid = (r.count != 2'h0);
	assign o_data = r.mem[0];
endmodule // sac_buf2

// ==== sac_host.sv ====
`timescale 1ns/1ps
module sac_host (
	input wire logic i_clk,
	input wire logic i_sck,
	input wire logic i_data,
	output logic o_conversion_start_n,
	output logic o_chip_select_n,
	output logic o_select,
	output logic o_sck
);
	logic [11:0] rx = 12'h000;
	logic sck_d = 1'b0;
	int n_rx = 0;
	int n_hi = 0;
	int t = 0;
	int t_first = 0;
	int t_last = 0;
	// Host clock idles low so the end update is never skipped by accident
	initial begin
		o_conversion_start_n = 1'b1;
		o_chip_select_n = 1'b0;
		o_select = 1'b0;
		o_sck = 1'b0;
	end
	// Internal clock only trusted while selected
	always @(posedge i_clk) begin
		t <= t + 1;
		sck_d <= i_sck;
		if (!o_select && !o_chip_select_n) begin
			if (i_sck)
				n_hi <= n_hi + 1;
			if (i_sck && !sck_d) begin
				rx <= {rx[10:0], i_data};
				n_rx <= n_rx + 1;
				t_last <= t;
				if (n_rx == 0)
					t_first <= t;
			end
		end
	end
	// Glitch variant pulses start again mid conversion on purpose
	task automatic start(input bit glitch);
		n_rx = 0;
		n_hi = 0;
		t = 0;
		o_conversion_start_n = 1'b0;
		repeat (glitch ? 2 : 300) @(posedge i_clk);
		#5 o_conversion_start_n = 1'b1;
		if (glitch) begin
			repeat (100) @(posedge i_clk);
			#5 o_conversion_start_n = 1'b0;
			repeat (3) @(posedge i_clk);
			#5 o_conversion_start_n = 1'b1;
		end
	endtask
	// Phases of several cycles so the synchroniser sees each edge
	task automatic read_ext(input int n);
		repeat (n) begin
			o_sck = 1'b1;
			repeat (3) @(posedge i_clk);
			#5 o_sck = 1'b0;
			repeat (4) @(posedge i_clk);
			#5 rx = {rx[10:0], i_data};
		end
	endtask
endmodule // sac_host

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import sac_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic valid = 1'b0;
	logic [RES_BITS-1:0] code = 12'h000;
	logic [RES_BITS-1:0] exp_sh = 12'h000;
	logic [RES_BITS-1:0] q[$];
	logic start_n, cs_n, sel, hsck, sck, sck_oe_n, dat, dat_oe_n, busy_n, busy_oe_n, sh, rdy;
	logic dat_last = 1'b0;
	logic sck_last = 1'b0;
	int n_fail = 0;
	int tests_run = 0;
	int seed = 11537;
	always #25 i_clk = ~i_clk;
	// Released lines show the inverse of their last driven level
	always @(posedge i_clk) begin
		if (!dat_oe_n)
			dat_last <= dat;
		if (!sck_oe_n)
			sck_last <= sck;
	end
	wire dat_w = dat_oe_n ? ~dat_last : dat;
	wire sck_w = !sck_oe_n ? sck : (sel ? hsck : ~sck_last);
	sac_ctrl u_sac_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
		.i_conversion_start_n(start_n), .i_chip_select_n(cs_n),
		.i_shift_clock_source_select(sel), .i_serial_shift_clock(sck_w),
		.o_serial_shift_clock(sck), .o_serial_shift_clock_oe_n(sck_oe_n),
		.o_serial_data(dat), .o_serial_data_oe_n(dat_oe_n), .o_busy_n(busy_n),
		.o_busy_oe_n(busy_oe_n), .o_sample_hold(sh), .i_result_valid(valid),
		.i_result_code(code), .o_result_ready(rdy));
	sac_host u_sac_host (.i_clk(i_clk), .i_sck(sck_w), .i_data(dat_w),
		.o_conversion_start_n(start_n), .o_chip_select_n(cs_n), .o_select(sel),
		.o_sck(hsck));
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#5;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		tests_run++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		if (n_fail == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// A third word while two wait is refused
	task automatic put(input logic [11:0] c);
		check(12'(rdy), 12'(q.size() < 2));
		if (q.size() < 2)
			q.push_back(c);
		code = c;
		valid = 1'b1;
		tick(1);
		valid = 1'b0;
		tick(1);
	endtask
	task automatic conversion_start_n(input bit glitch, input bit skip);
		int k;
		int n;
		logic [11:0] old;
		old = exp_sh;
		k = 0;
		n = 1;
		fork
			u_sac_host.start(glitch);
			begin
				while (busy_n !== 1'b0 && k < 9) begin
					tick(1);
					k++;
				end
				check(12'(k), 12'h002);
				tick(1);
				check(12'(sh), 12'h001);
				while (busy_n === 1'b0 && n < 999) begin
					tick(1);
					n++;
				end
				check(12'(n), 12'h126);
			end
		join
		if (k >= 9 || n >= 999)
			wrap_up();
		check(12'({dat_oe_n, busy_oe_n, sck_oe_n}), cs_n ? 12'h007 : 12'(sel));
		if (q.size() > 0) begin
			old = q.pop_front();
			if (!skip)
				exp_sh = old;
		end
		tick(220);
	endtask
	task automatic conversion_start_n_int(input bit glitch);
		logic [11:0] want;
		want = exp_sh;
		conversion_start_n(glitch, 1'b0);
		check(u_sac_host.rx, want);
		check(12'(u_sac_host.n_rx), 12'h00c);
		check(12'(u_sac_host.n_hi), 12'h054);
		check(12'(u_sac_host.t_last - u_sac_host.t_first), 12'h0f2);
		check(12'(u_sac_host.t_first inside {[27:32]}), 12'h001);
	endtask
	initial begin
		tick(6);
		i_rst = 1'b0;
		check(12'({busy_n, dat_oe_n, rdy}), 12'h007);
		put(12'h7ff);
		put(12'h800);
		put(12'h123);
		conversion_start_n_int(1'b0);
		conversion_start_n_int(1'b1);
		put(12'h000);
		u_sac_host.o_chip_select_n = 1'b1;
		conversion_start_n(1'b0, 1'b0);
		u_sac_host.o_chip_select_n = 1'b0;
		put(12'hfff);
		conversion_start_n_int(1'b0);
		repeat (3) begin
			put(12'($random(seed)));
			conversion_start_n_int(1'b0);
		end
		u_sac_host.o_select = 1'b1;
		put(12'($random(seed)));
		conversion_start_n(1'b0, 1'b0);
		// Clock raised while deselected, so no shift edge is seen
		u_sac_host.o_chip_select_n = 1'b1;
		u_sac_host.o_sck = 1'b1;
		tick(4);
		u_sac_host.o_chip_select_n = 1'b0;
		put(12'($random(seed)));
		conversion_start_n(1'b0, 1'b1);
		u_sac_host.o_sck = 1'b0;
		tick(4);
		u_sac_host.read_ext(12);
		check(u_sac_host.rx, exp_sh);
		u_sac_host.read_ext(1);
		check(12'(u_sac_host.rx[0]), 12'h000);
		wrap_up();
	end
endmodule // tb_top
